// ### src/stop_pkg.sv
package stop_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_RTI    = 4'h2;
  localparam logic [3:0] REG_ACK    = 4'h3;

  // Control and acknowledge register field positions
  localparam int CTRL_STOP_INSTR_ENABLE  = 0;
  localparam int CTRL_PDC    = 1;
  localparam int CTRL_PARTIAL_POWERDOWN_SELECT   = 2;
  localparam int CTRL_LOW_VOLTAGE_RESET_ENABLE  = 3;
  localparam int CTRL_DBGEN  = 4;
  localparam int ACK_PPD     = 0;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [2:0] RTI_OFF    = 3'h0;

  // Self-clocked tick: about 1 kHz from the 10 MHz clock
  localparam int CLK_HZ      = 10_000_000;
  localparam int RTI_SRC_HZ  = 1_000;
  localparam int RTI_TICK_CY = CLK_HZ / RTI_SRC_HZ;

  // Vector numbers reported on wakeup
  localparam logic [3:0] VEC_RESET = 4'h0;
  localparam logic [3:0] VEC_IRQ   = 4'h3;
  localparam logic [3:0] VEC_KBA   = 4'hc;
  localparam logic [3:0] VEC_KBB   = 4'hd;
  localparam logic [3:0] VEC_RTI   = 4'he;

  // Error status for memory-access-with-status in stop
  localparam logic [7:0] DBG_ERR_STOP = 8'hc0;
  localparam logic [7:0] DBG_OK       = 8'h00;

  typedef enum logic [1:0] {
    MODE_STOP3,
    MODE_STOP2,
    MODE_STOP1
  } stop_mode_t;

  typedef enum {
    ST_RUN,
    ST_STOP,
    ST_WAKE
  } pwr_state_t;

  // Clock and power gating outputs
  typedef struct packed {
    logic periph_clk_en;
    logic osc_en;
    logic dbg_clk_en;
    logic reg_standby;
    logic cmp_standby;
    logic rti_src_en;
  } power_ctl_t;

  // Wakeup sources
  typedef struct packed {
    logic reset_pin;
    logic irq_pin;
    logic kba_pin;
    logic kbb_pin;
  } wake_src_t;

endpackage

// ### src/stop_mode_power_controller.sv
`timescale 1ns/100ps
// How it works
// - Stop3 halts clocks, retains all state
// - Stop3 exits on reset, enabled pins, timer
// - Reset exit resets; interrupt exit gives vector
// - Realtime tick from self-clocked 1 kHz source
// - Period select zero disables tick and source
// - Debug enable keeps debug clocks, full regulation
// - Debug enable refuses stop1 and stop2
// - Memory status commands in stop return stop error
// - Enter-debug command wakes when debug enabled
// - Low-voltage reset forces stop3, regulator on
// - Peripheral clocks stop in every stop mode
// - Stop2 latches pins until acknowledge
// - Stop1 forces pins to reset state
// - Stop2 wakeup resets registers, keeps RAM
// - Stop1 wakeup resets registers, RAM lost
// - Timer and serial modules stop, reset after stop1/2
// - Comparator standby in stop, reset after stop1/2
// - Keyboard group a active-low wake in stop1/2
// - Regulator standby unless lvd reset or debug
// - Stop with enable clear forces illegal reset
// - Powerdown set, partial clear selects stop1
// - Powerdown and partial set selects stop2
// - Stop2 wakeup sets flag until acknowledged
module stop_mode_power_controller
  import stop_pkg::*;
#(
  parameter int RTI_DIV = RTI_TICK_CY
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  // CPU side
  input  wire logic        stop_instr_in,
  input  wire logic        irq_enable_in,
  input  wire logic        irq_pin_in,
  input  wire logic        kba_enable_in,
  input  wire logic        kba_pin_in,
  input  wire logic        kba_active_low_in,
  input  wire logic        kbb_enable_in,
  input  wire logic        kbb_pin_in,
  input  wire logic        reset_pin_n_in,
  // Debug commands
  input  wire logic        dbg_mem_status_cmd_in,
  input  wire logic        dbg_enter_cmd_in,
  output logic      [7:0]  dbg_status_out,
  output logic             dbg_active_out,
  // Power and gating
  output power_ctl_t       power_out,
  output logic             in_stop_out,
  output stop_mode_t       mode_out,
  output logic             pin_latch_out,
  output logic             pin_force_reset_out,
  output logic             ram_retain_out,
  // Resets and wakeup
  output logic             sys_reset_out,
  output logic             illegal_op_reset_out,
  output logic             periph_reset_out,
  output logic             wake_out,
  output logic      [3:0]  wake_vector_out
);

  // Refuse a divider that the tick counter cannot serve
  if (RTI_DIV < 2 || RTI_DIV >= (1 << 24)) begin : g_bad_div
    $error("RTI_DIV must lie between 2 and 2**24-1");
  end

  logic [7:0]  ctrl_q;
  logic [2:0]  rti_sel_q;
  logic        partial_powerdown_flag_q;
  logic        latch_q;
  pwr_state_t  state_q;
  stop_mode_t  mode_q;
  logic        dbg_kept_q;
  logic        lvd_kept_q;
  logic        rti_tick_q;
  logic [31:0] rti_cnt_q;
  logic [31:0] rti_lim_q;
  logic [3:0]  vec_q;
  logic        wake_q;
  logic        sysrst_q;
  logic        illrst_q;
  logic        dbg_act_q;
  logic [7:0]  dbg_stat_q;
  logic [7:0]  rdata_q;

  logic       stop_instr_enable, powerdown_control, partial_powerdown_select, low_voltage_reset_enable, dbgen;
  stop_mode_t sel_mode;
  logic       kba_wake, irq_wake, kbb_wake, rti_en, any_wake;
  logic       ack_wr;

  assign stop_instr_enable = ctrl_q[CTRL_STOP_INSTR_ENABLE];
  assign powerdown_control   = ctrl_q[CTRL_PDC];
  assign partial_powerdown_select  = ctrl_q[CTRL_PARTIAL_POWERDOWN_SELECT];
  assign low_voltage_reset_enable = ctrl_q[CTRL_LOW_VOLTAGE_RESET_ENABLE];
  assign dbgen = ctrl_q[CTRL_DBGEN];
  assign ack_wr = reg_wr_in && reg_addr_in == REG_ACK
                  && reg_wdata_in[ACK_PPD];

  // Mode selection from powerdown bits and overrides
  always_comb begin
    if (!powerdown_control || low_voltage_reset_enable || dbgen) begin
      sel_mode = MODE_STOP3;
    end else if (partial_powerdown_select) begin
      sel_mode = MODE_STOP2;
    end else begin
      sel_mode = MODE_STOP1;
    end
  end

  // Wakeup qualification per mode
  always_comb begin
    rti_en   = rti_sel_q != RTI_OFF;
    irq_wake = irq_enable_in && !irq_pin_in;
    if (mode_q == MODE_STOP3) begin
      kba_wake = kba_enable_in &&
                 (kba_pin_in ^ kba_active_low_in);
      kbb_wake = kbb_enable_in && !kbb_pin_in;
    end else begin
      kba_wake = kba_enable_in && !kba_pin_in;
      kbb_wake = 1'b0;
    end
    any_wake = irq_wake || kba_wake || kbb_wake ||
               (rti_tick_q && rti_en && mode_q != MODE_STOP1);
  end

  // Control registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_q    <= CTRL_RESET;
      rti_sel_q <= RTI_OFF;
    end else if (state_q == ST_WAKE && mode_q != MODE_STOP3) begin
      ctrl_q    <= CTRL_RESET;
      rti_sel_q <= RTI_OFF;
    end else if (reg_wr_in && reg_addr_in == REG_CTRL) begin
      ctrl_q <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == REG_RTI) begin
      rti_sel_q <= reg_wdata_in[2:0];
    end
  end

  // Self-clocked tick divider
  always_ff @(posedge clk_in) begin
    if (rst_in || !rti_en) begin
      rti_cnt_q  <= 32'h0;
      rti_tick_q <= 1'b0;
      rti_lim_q  <= 32'(RTI_DIV);
    end else begin
      rti_lim_q <= 32'(RTI_DIV) << rti_sel_q;
      if (rti_cnt_q >= rti_lim_q - 32'h1) begin
        rti_cnt_q  <= 32'h0;
        rti_tick_q <= 1'b1;
      end else begin
        rti_cnt_q  <= rti_cnt_q + 32'h1;
        rti_tick_q <= 1'b0;
      end
    end
  end

  // Power state machine
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q    <= ST_RUN;
      mode_q     <= MODE_STOP3;
      dbg_kept_q <= 1'b0;
      lvd_kept_q <= 1'b0;
      wake_q     <= 1'b0;
      vec_q      <= VEC_RESET;
      sysrst_q   <= 1'b0;
      illrst_q   <= 1'b0;
      dbg_act_q  <= 1'b0;
    end else begin
      wake_q   <= 1'b0;
      sysrst_q <= 1'b0;
      illrst_q <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (dbg_act_q && !dbg_enter_cmd_in) begin
            dbg_act_q <= 1'b1;
          end
          if (stop_instr_in && !stop_instr_enable) begin
            illrst_q <= 1'b1;
          end else if (stop_instr_in) begin
            state_q    <= ST_STOP;
            mode_q     <= sel_mode;
            dbg_kept_q <= dbgen;
            lvd_kept_q <= low_voltage_reset_enable;
          end
        end
        ST_STOP: begin
          if (!reset_pin_n_in) begin
            state_q  <= ST_WAKE;
            sysrst_q <= 1'b1;
            vec_q    <= VEC_RESET;
            wake_q   <= 1'b1;
          end else if (dbg_enter_cmd_in && dbg_kept_q) begin
            state_q   <= ST_RUN;
            dbg_act_q <= 1'b1;
          end else if (any_wake) begin
            state_q <= ST_WAKE;
            wake_q  <= 1'b1;
            if (mode_q != MODE_STOP3) begin
              sysrst_q <= 1'b1;
              vec_q    <= VEC_RESET;
            end else if (irq_wake) begin
              vec_q <= VEC_IRQ;
            end else if (kba_wake) begin
              vec_q <= VEC_KBA;
            end else if (kbb_wake) begin
              vec_q <= VEC_KBB;
            end else begin
              vec_q <= VEC_RTI;
            end
          end
        end
        ST_WAKE: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Partial powerdown flag and pin latch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      partial_powerdown_flag_q  <= 1'b0;
      latch_q <= 1'b0;
    end else if (state_q == ST_RUN && stop_instr_in && stop_instr_enable
                 && sel_mode == MODE_STOP2) begin
      latch_q <= 1'b1;
    end else if (state_q == ST_WAKE && mode_q == MODE_STOP2) begin
      partial_powerdown_flag_q <= 1'b1;
    end else if (ack_wr) begin
      partial_powerdown_flag_q  <= 1'b0;
      latch_q <= 1'b0;
    end
  end

  // Debug status answers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dbg_stat_q <= DBG_OK;
    end else if (dbg_mem_status_cmd_in) begin
      dbg_stat_q <= (state_q == ST_STOP) ? DBG_ERR_STOP
                                        : DBG_OK;
    end
  end

  // Register read port
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        REG_CTRL:   rdata_q <= ctrl_q;
        REG_STATUS: rdata_q <= {4'h0, partial_powerdown_flag_q, latch_q,
                                2'(mode_q)};
        REG_RTI:    rdata_q <= {5'h00, rti_sel_q};
        default:    rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Gating outputs
  always_comb begin
    logic stopped;
    stopped = state_q == ST_STOP;
    power_out.periph_clk_en = !stopped;
    power_out.osc_en      = !stopped || lvd_kept_q;
    power_out.dbg_clk_en  = !stopped || dbg_kept_q;
    power_out.reg_standby = stopped && !dbg_kept_q
                            && !lvd_kept_q;
    power_out.cmp_standby = stopped;
    power_out.rti_src_en  = rti_en;
  end

  assign in_stop_out         = state_q == ST_STOP;
  assign mode_out            = mode_q;
  assign pin_latch_out       = latch_q;
  assign pin_force_reset_out = state_q == ST_STOP
                               && mode_q == MODE_STOP1;
  assign ram_retain_out      = !(state_q == ST_STOP
                               && mode_q == MODE_STOP1);
  assign sys_reset_out       = sysrst_q;
  assign illegal_op_reset_out = illrst_q;
  assign periph_reset_out    = state_q == ST_WAKE
                               && mode_q != MODE_STOP3;
  assign wake_out            = wake_q;
  assign wake_vector_out     = vec_q;
  assign dbg_status_out      = dbg_stat_q;
  assign dbg_active_out      = dbg_act_q;
  assign reg_rdata_out       = rdata_q;

  // Checks
  a_stop_instr_enable_refuse: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ST_RUN && stop_instr_in && !stop_instr_enable |=>
      illegal_op_reset_out && !in_stop_out)
    else $error("stop without enable not refused");
  a_dbg_stop3: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ST_RUN && stop_instr_in && stop_instr_enable && dbgen |=>
      mode_q == MODE_STOP3)
    else $error("debug enable did not force stop3");
  a_lvd_stop3: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ST_RUN && stop_instr_in && stop_instr_enable && low_voltage_reset_enable |=>
      mode_q == MODE_STOP3 && !power_out.reg_standby)
    else $error("low voltage reset did not force stop3");
  a_periph_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    in_stop_out |-> !power_out.periph_clk_en)
    else $error("peripheral clock running in stop");
  a_reg_standby: assert property (@(posedge clk_in) disable iff (rst_in)
    in_stop_out && !dbg_kept_q && !lvd_kept_q |->
      power_out.reg_standby)
    else $error("regulator not in standby");
  a_mem_status: assert property (@(posedge clk_in) disable iff (rst_in)
    in_stop_out && dbg_mem_status_cmd_in |=>
      dbg_status_out == DBG_ERR_STOP)
    else $error("no stop error status");
  a_reset_vector: assert property (@(posedge clk_in) disable iff (rst_in)
    in_stop_out && !reset_pin_n_in |=>
      sys_reset_out && wake_vector_out == VEC_RESET)
    else $error("reset pin exit did not reset");
  a_partial_powerdown_flag_set: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == ST_WAKE && mode_q == MODE_STOP2 |=>
      partial_powerdown_flag_q ##1 partial_powerdown_flag_q || $past(ack_wr))
    else $error("partial powerdown flag not set");
  c_stop2: cover property (@(posedge clk_in)
    in_stop_out && mode_q == MODE_STOP2 ##[1:100] wake_out);
  c_stop3_irq: cover property (@(posedge clk_in)
    wake_out && wake_vector_out == VEC_IRQ);
  c_dbg_wake: cover property (@(posedge clk_in)
    in_stop_out ##1 dbg_active_out);
  c_stop1_wake: cover property (@(posedge clk_in)
    wake_out && mode_q == MODE_STOP1);

  // Pin latch, tick source, wakeup and RAM retention checks
  a_latch_entry: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state_q == ST_RUN && stop_instr_in && stop_instr_enable && sel_mode == MODE_STOP2
      |=> pin_latch_out && in_stop_out)
    else $error("pins not latched on stop2 entry");
  a_latch_hold: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pin_latch_out && !ack_wr |=> pin_latch_out)
    else $error("pin latch dropped without acknowledge");
  a_rti_off: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rti_sel_q == RTI_OFF |-> !power_out.rti_src_en ##1 !rti_tick_q)
    else $error("tick source running with period select zero");
  a_deep_wake: assert property (
    @(posedge clk_in) disable iff (rst_in)
    wake_out && mode_q != MODE_STOP3 |->
      sys_reset_out && periph_reset_out && wake_vector_out == VEC_RESET)
    else $error("deep stop wakeup without reset");
  a_deep_regs: assert property (
    @(posedge clk_in) disable iff (rst_in)
    state_q == ST_WAKE && mode_q != MODE_STOP3 |=>
      ctrl_q == CTRL_RESET && rti_sel_q == RTI_OFF)
    else $error("registers kept after deep stop wakeup");
  a_dbg_wake: assert property (
    @(posedge clk_in) disable iff (rst_in)
    in_stop_out && reset_pin_n_in && dbg_enter_cmd_in && dbg_kept_q |=>
      dbg_active_out && !in_stop_out)
    else $error("enter-debug command did not wake");
  a_irq_vector: assert property (
    @(posedge clk_in) disable iff (rst_in)
    in_stop_out && mode_q == MODE_STOP3 && reset_pin_n_in && irq_wake
      && !(dbg_enter_cmd_in && dbg_kept_q) |=>
      wake_out && !sys_reset_out && wake_vector_out == VEC_IRQ)
    else $error("interrupt wakeup gave wrong vector");
  a_ram_keep: assert property (
    @(posedge clk_in) disable iff (rst_in)
    in_stop_out && mode_q != MODE_STOP1 |-> ram_retain_out)
    else $error("ram not retained in stop2 or stop3");

endmodule

// ### sim/cpu_pins_model.sv
`timescale 1ns/100ps
// Stands in for the CPU core and the wakeup pins
module cpu_pins_model (
  // Clock
  input  wire logic       clk_in,
  // Levels {irq_en,irq,kba_en,kba,kba_low,kbb_en,kbb,reset_n}
  output logic      [7:0] pins_out,
  // One-cycle requests
  output logic            stop_out,
  output logic            mem_cmd_out,
  output logic            enter_cmd_out
);
  // All pins idle high, no request
  initial begin
    pins_out = 8'hff;
    stop_out = 1'b0;
    mem_cmd_out = 1'b0;
    enter_cmd_out = 1'b0;
  end

  // New pin levels just after an edge
  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_in);
    pins_out <= v;
  endtask

  // Request: 0 stop, 1 memory status, 2 enter debug
  task automatic pulse(input int which);
    @(posedge clk_in);
    case (which)
      0: stop_out <= 1'b1;
      1: mem_cmd_out <= 1'b1;
      default: enter_cmd_out <= 1'b1;
    endcase
    @(posedge clk_in);
    stop_out <= 1'b0;
    mem_cmd_out <= 1'b0;
    enter_cmd_out <= 1'b0;
  endtask
endmodule

// ### sim/stop_mode_power_controller_tb_top.sv
`timescale 1ns/100ps
module stop_mode_power_controller_tb_top
  import stop_pkg::*;
;
  logic       clk_in, rst_in, reg_wr_in, reg_rd_in;
  logic [3:0] reg_addr_in, wake_vector_out;
  logic [7:0] reg_wdata_in, reg_rdata_out, dbg_status_out, pins, d;
  logic       stop_i, mem_cmd, enter_cmd, dbg_active_out, in_stop_out;
  logic       pin_latch_out, pin_force_reset_out, ram_retain_out;
  logic       sys_reset_out, illegal_op_reset_out, periph_reset_out;
  logic       wake_out;
  power_ctl_t power_out;
  stop_mode_t mode_out;
  int         err_count, tests_run;

  // Far side and design
  cpu_pins_model cpu (.clk_in, .pins_out(pins), .stop_out(stop_i),
    .mem_cmd_out(mem_cmd), .enter_cmd_out(enter_cmd));
  stop_mode_power_controller #(.RTI_DIV(4)) dut (.clk_in, .rst_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .stop_instr_in(stop_i), .irq_enable_in(pins[7]), .irq_pin_in(pins[6]),
    .kba_enable_in(pins[5]), .kba_pin_in(pins[4]),
    .kba_active_low_in(pins[3]), .kbb_enable_in(pins[2]),
    .kbb_pin_in(pins[1]), .reset_pin_n_in(pins[0]),
    .dbg_mem_status_cmd_in(mem_cmd), .dbg_enter_cmd_in(enter_cmd),
    .dbg_status_out, .dbg_active_out, .power_out, .in_stop_out, .mode_out,
    .pin_latch_out, .pin_force_reset_out, .ram_retain_out, .sys_reset_out,
    .illegal_op_reset_out, .periph_reset_out, .wake_out, .wake_vector_out);

  // Clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Register port cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // Stop request, then mode and masked gating
  task automatic stop_chk(input stop_mode_t m, input logic [7:0] msk,
                          input logic [7:0] exp);
    cpu.pulse(0);
    #1 check(8'(in_stop_out), 8'h01);
    check(8'(mode_out), 8'(m));
    check(8'(power_out) & msk, exp);
  endtask

  task automatic wait_wake(input logic rst_exp, input logic [3:0] vec);
    for (int n = 0; n < 40 && wake_out !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
    end
    check(8'(wake_out), 8'h01);
    check(8'(sys_reset_out), 8'(rst_exp));
    check(8'(wake_vector_out), 8'(vec));
  endtask

  task automatic no_wake;
    repeat (12) begin
      @(posedge clk_in);
      #1 check(8'(wake_out || !in_stop_out), 8'h00);
    end
  endtask

  task automatic idle;
    cpu.set_pins(8'hff);
    repeat (2) @(posedge clk_in);
  endtask

  // Cut a hang short
  initial begin
    repeat (3000) @(posedge clk_in);
    err_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    rst_in = 1'b1;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 check(8'(power_out), 8'h38);
    rd(REG_CTRL);
    check(d, CTRL_RESET);
    rd(4'h7);
    check(d, 8'h00);
    wr(REG_CTRL, 8'h00);
    cpu.pulse(0);
    #1 check(8'(illegal_op_reset_out), 8'h01);
    check(8'(in_stop_out), 8'h00);
    repeat (3) @(posedge clk_in);
    wr(REG_CTRL, 8'h01);
    stop_chk(MODE_STOP3, 8'h3f, 8'h06);
    check(8'(ram_retain_out), 8'h01);
    no_wake();
    cpu.set_pins(8'hbf);
    wait_wake(1'b0, VEC_IRQ);
    idle();
    stop_chk(MODE_STOP3, 8'h3f, 8'h06);
    cpu.set_pins(8'hfe);
    wait_wake(1'b1, VEC_RESET);
    idle();
    stop_chk(MODE_STOP3, 8'h3f, 8'h06);
    cpu.set_pins(8'hfd);
    wait_wake(1'b0, VEC_KBB);
    idle();
    wr(REG_RTI, 8'h01);
    stop_chk(MODE_STOP3, 8'h3f, 8'h07);
    wait_wake(1'b0, VEC_RTI);
    idle();
    wr(REG_RTI, 8'h00);
    cpu.set_pins(8'he7);
    stop_chk(MODE_STOP3, 8'h3f, 8'h06);
    cpu.set_pins(8'hf7);
    wait_wake(1'b0, VEC_KBA);
    repeat (2) @(posedge clk_in);
    wr(REG_CTRL, 8'h07);
    stop_chk(MODE_STOP2, 8'h3f, 8'h06);
    check(8'(pin_latch_out), 8'h01);
    no_wake();
    cpu.set_pins(8'he7);
    wait_wake(1'b1, VEC_RESET);
    check(8'(periph_reset_out), 8'h01);
    idle();
    rd(REG_STATUS);
    check(d & 8'h0c, 8'h0c);
    rd(REG_CTRL);
    check(d, CTRL_RESET);
    wr(REG_ACK, 8'h01);
    rd(REG_STATUS);
    check(d & 8'h0c, 8'h00);
    check(8'(pin_latch_out), 8'h00);
    wr(REG_CTRL, 8'h03);
    stop_chk(MODE_STOP1, 8'h3f, 8'h06);
    check(8'({pin_force_reset_out, ram_retain_out}), 8'h02);
    cpu.set_pins(8'hfd);
    no_wake();
    cpu.set_pins(8'hbd);
    wait_wake(1'b1, VEC_RESET);
    idle();
    wr(REG_CTRL, 8'h0b);
    stop_chk(MODE_STOP3, 8'h27, 8'h02);
    cpu.set_pins(8'hbf);
    wait_wake(1'b0, VEC_IRQ);
    idle();
    wr(REG_CTRL, 8'h13);
    stop_chk(MODE_STOP3, 8'h2f, 8'h0a);
    cpu.pulse(1);
    #1 check(dbg_status_out, DBG_ERR_STOP);
    cpu.pulse(2);
    for (int n = 0; n < 20 && dbg_active_out !== 1'b1; n++) begin
      #1;
      @(posedge clk_in);
    end
    #1 check(8'({dbg_active_out, in_stop_out}), 8'h02);
    cpu.pulse(1);
    #1 check(dbg_status_out, DBG_OK);
    // Mid-run reset, then disabled sources must not wake
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1 check(8'(power_out), 8'h38);
    check(8'({dbg_active_out, in_stop_out}), 8'h00);
    rd(REG_CTRL);
    check(d, CTRL_RESET);
    cpu.set_pins(8'h09);
    stop_chk(MODE_STOP3, 8'h3f, 8'h06);
    no_wake();
    cpu.set_pins(8'h08);
    wait_wake(1'b1, VEC_RESET);
    print_verdict();
  end
endmodule
